//--- pas_host.sv
// host end: boot sequencer with verify and retry, AXI4-Lite register slave for software
// assumes the device answers every command; ROM sits on page lines and device address latch
`timescale 1ns/10ps
`default_nettype none
module pas_host
	import pas_pkg::*;
#(
	parameter int LOAD_CYC  = LOAD_WAIT_CYC,
	parameter int RETRY_CYC = RETRY_WAIT_CYC,
	parameter int RST_CYC   = RST_HOLD_CYC,
	parameter int BOOTS     = MAX_BOOTS
)(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// link
	pas_link_if.host         link,
	// device interrupt, masked until boot verified
	output logic             irq_out
);
	generate
		if (LOAD_CYC < 1 || RETRY_CYC < 1 || RST_CYC < 1 || LOAD_CYC >= (1 << CNT_W) ||
			RETRY_CYC >= (1 << CNT_W) || RST_CYC >= (1 << CNT_W) || BOOTS < 1 || BOOTS > 15)
			$error("pas_host: unsupported parameters");
	endgenerate

	typedef enum logic [8:0] {
		H_IDLE    = 9'h001,
		H_RESET   = 9'h002,
		H_RELEASE = 9'h004,
		H_LOAD    = 9'h008,
		H_READ1   = 9'h010,
		H_GAP     = 9'h020,
		H_READ2   = 9'h040,
		H_READY   = 9'h080,
		H_FAIL    = 9'h100
	} pas_hstate_t;

	function automatic logic pas_hit(input logic [7:0] a);
		pas_hit = a == REG_CTRL || a == REG_EXPECT || a == REG_CMD || a == REG_STATUS ||
			a == REG_RESULT;
	endfunction

	pas_hstate_t             state;
	logic [CNT_W-1:0]        cnt;
	logic [3:0]              boots;
	logic [7:0]              ctrl;
	logic [DATA_W-1:0]       expect_val;
	logic [DATA_W-1:0]       result;
	logic                    last_err;
	logic                    cmd_busy;
	logic                    aw_have;
	logic                    w_have;
	logic [7:0]              awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic [1:0]              irq_sync;
	logic                    reset_n;
	logic                    boot_oe;
	logic                    cmd_valid;
	pas_cmd_t                cmd_code;
	logic [DATA_W-1:0]       cmd_data;

	wire wr_fire   = aw_have && w_have && !s_axi_bvalid_out;
	wire wr_lane0  = wr_fire && wstrb_q[0];
	wire start_req = wr_lane0 && awaddr_q == REG_CTRL && wdata_q[CTRL_START_BIT];
	wire cmd_req   = wr_lane0 && awaddr_q == REG_CMD && state == H_READY && !cmd_busy;
	wire rd_fire   = s_axi_arvalid_in && s_axi_arready_out;
	wire idle_like = state == H_IDLE || state == H_READY || state == H_FAIL;
	wire match     = link.rsp_valid && !link.rsp_err && link.rsp_data == expect_val;
	wire [31:0] status_word = {20'h0, boots, 2'h0, last_err, cmd_busy, irq_out,
		state == H_FAIL, state == H_READY, !idle_like};
	wire [31:0] rd_word =
		s_axi_araddr_in == REG_CTRL   ? {24'h0, ctrl} :
		s_axi_araddr_in == REG_EXPECT ? {24'h0, expect_val} :
		s_axi_araddr_in == REG_STATUS ? status_word :
		s_axi_araddr_in == REG_RESULT ? {24'h0, result} : 32'h0;

	assign link.dev_reset_n        = reset_n;
	assign link.page_lines         = ctrl[CTRL_PAGE_LSB +: PAGE_LINES];
	assign link.memory_bank_select = ctrl[CTRL_BANK_BIT];
	assign link.mode_pins          = ctrl[CTRL_MODE_LSB +: MODE_W];
	assign link.host_boot_out      = 1'b0;
	assign link.host_boot_oe       = boot_oe;
	assign link.cmd_valid          = cmd_valid;
	assign link.cmd_code           = cmd_code;
	assign link.cmd_data           = cmd_data;

	// AXI4-Lite handshakes, one write and one read at a time
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= AXI_OKAY;
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= AXI_OKAY;
			aw_have           <= 1'b0;
			w_have            <= 1'b0;
			awaddr_q          <= 8'h00;
			wdata_q           <= 32'h0;
			wstrb_q           <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_have           <= 1'b1;
				awaddr_q          <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_have           <= 1'b1;
				wdata_q          <= s_axi_wdata_in;
				wstrb_q          <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire)
			begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= pas_hit(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
				aw_have          <= 1'b0;
				w_have           <= 1'b0;
			end
			if (s_axi_bvalid_out && s_axi_bready_in)
			begin
				s_axi_bvalid_out  <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
			if (rd_fire)
			begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rdata_out   <= rd_word;
				s_axi_rresp_out   <= pas_hit(s_axi_araddr_in) ? AXI_OKAY : AXI_SLVERR;
			end
			if (s_axi_rvalid_out && s_axi_rready_in)
			begin
				s_axi_rvalid_out  <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
		end
	end

	// software registers; start bit is a pulse and is not stored
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ctrl       <= {4'h0, CTRL_PAGE_RESET, 1'b0};
			expect_val <= 8'h5a;
			irq_sync   <= 2'h3;
			irq_out    <= 1'b0;
		end
		else
		begin
			if (wr_lane0 && awaddr_q == REG_CTRL)
				ctrl <= {wdata_q[7:1], 1'b0};
			if (wr_lane0 && awaddr_q == REG_EXPECT)
				expect_val <= wdata_q[7:0];
			irq_sync <= {irq_sync[0], link.autoboot_request_pin};
			irq_out  <= state == H_READY && !irq_sync[1];
		end
	end

	// boot sequencer
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state     <= H_IDLE;
			cnt       <= '0;
			boots     <= 4'h0;
			reset_n   <= 1'b0;
			boot_oe   <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_code  <= PAS_CMD_READ;
			cmd_data  <= '0;
			cmd_busy  <= 1'b0;
			result    <= '0;
			last_err  <= 1'b0;
		end
		else
		begin
			cmd_valid <= 1'b0;
			if (link.rsp_valid)
			begin
				result   <= link.rsp_data;
				last_err <= link.rsp_err;
				cmd_busy <= 1'b0;
			end
			if (start_req && idle_like)
			begin
				state   <= H_RESET;
				cnt     <= CNT_W'(RST_CYC - 1);
				boots   <= 4'h1;
				reset_n <= 1'b0;
				boot_oe <= 1'b1;
			end
			else
			begin
				unique case (state)
					H_IDLE, H_FAIL:
					begin
					end
					H_RESET:
					begin
						if (cnt != '0)
							cnt <= cnt - CNT_W'(1);
						else
						begin
							state   <= H_RELEASE;
							reset_n <= 1'b1;
						end
					end
					H_RELEASE:
					begin
						state   <= H_LOAD;
						boot_oe <= 1'b0;
						cnt     <= CNT_W'(LOAD_CYC - 1);
					end
					H_LOAD:
					begin
						if (cnt != '0)
							cnt <= cnt - CNT_W'(1);
						else
						begin
							state     <= H_READ1;
							cmd_valid <= 1'b1;
							cmd_code  <= PAS_CMD_READ;
							cmd_busy  <= 1'b1;
						end
					end
					H_READ1:
					begin
						if (link.rsp_valid)
						begin
							state <= match ? H_READY : H_GAP;
							cnt   <= CNT_W'(RETRY_CYC - 1);
						end
					end
					H_GAP:
					begin
						if (cnt != '0)
							cnt <= cnt - CNT_W'(1);
						else
						begin
							state     <= H_READ2;
							cmd_valid <= 1'b1;
							cmd_code  <= PAS_CMD_READ;
							cmd_busy  <= 1'b1;
						end
					end
					H_READ2:
					begin
						if (link.rsp_valid && match)
							state <= H_READY;
						else if (link.rsp_valid && boots == 4'(BOOTS))
							state <= H_FAIL;
						else if (link.rsp_valid)
						begin
							state   <= H_RESET;
							cnt     <= CNT_W'(RST_CYC - 1);
							boots   <= boots + 4'h1;
							reset_n <= 1'b0;
							boot_oe <= 1'b1;
						end
					end
					H_READY:
					begin
						if (cmd_req)
						begin
							cmd_valid <= 1'b1;
							cmd_code  <= pas_cmd_t'(wdata_q[CMD_CODE_LSB +: 2]);
							cmd_data  <= wdata_q[7:0];
							cmd_busy  <= 1'b1;
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

//--- pas_pkg.sv
// constants, field layouts and command codes shared by both ends of the autoboot link
// assumes a single 100 MHz clock shared by host and device logic
`default_nettype none
package pas_pkg;
	localparam int CLK_HZ         = 100_000_000;
	localparam int CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int LOAD_WAIT_MS   = 175;
	localparam int RETRY_WAIT_MS  = 5;
	localparam int RST_HOLD_NS    = 1000;
	localparam int ROM_ACCESS_NS  = 330;
	localparam int LOAD_WAIT_CYC  = LOAD_WAIT_MS * (CLK_HZ / 1000);
	localparam int RETRY_WAIT_CYC = RETRY_WAIT_MS * (CLK_HZ / 1000);
	localparam int RST_HOLD_CYC   = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int ROM_WAIT_CYC   = (ROM_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_STAGES    = 2;
	// memory geometry
	localparam int PAGE_BYTES     = 32768;
	localparam int PAGE_AW        = 15;
	localparam int LATCH_AW       = 16;
	localparam int PAGE_LINES     = 3;
	localparam int MODE_W         = 2;
	localparam int DATA_W         = 8;
	localparam int CNT_W          = 25;
	localparam int MAX_BOOTS      = 3;
	localparam int VAR_OFFSET     = 16;
	// hardware configuration byte: low nibble input ports, high nibble output port
	localparam logic [7:0] CFG_IN_MASK = 8'h0f;
	localparam logic [7:0] CFG_DEFAULT = 8'h00;
	typedef enum logic [1:0] {
		PAS_CMD_READ    = 2'h0,
		PAS_CMD_CONFIG  = 2'h1,
		PAS_CMD_KICK    = 2'h2,
		PAS_CMD_RESTART = 2'h3
	} pas_cmd_t;
	// host register map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_EXPECT = 8'h04;
	localparam logic [7:0] REG_CMD    = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RESULT = 8'h10;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_PAGE_LSB  = 1;
	localparam int CTRL_BANK_BIT  = 4;
	localparam int CTRL_MODE_LSB  = 5;
	localparam int CMD_CODE_LSB   = 8;
	localparam logic [2:0] CTRL_PAGE_RESET = 3'h6;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- pas_link_if.sv
// link between host sequencer and decoder: reset, page select, open-drain boot pin, commands
// assumes the bench joins both ends on one clock; pull-up on the boot pin is modelled here
`timescale 1ns/10ps
`default_nettype none
interface pas_link_if;
	import pas_pkg::*;
	logic                  dev_reset_n;
	logic [PAGE_LINES-1:0] page_lines;
	logic                  memory_bank_select;
	logic [MODE_W-1:0]     mode_pins;
	logic                  host_boot_out;
	logic                  host_boot_oe;
	logic                  dev_irq_out;
	logic                  dev_irq_oe;
	wire                   autoboot_request_pin;
	logic                  cmd_valid;
	pas_cmd_t              cmd_code;
	logic [DATA_W-1:0]     cmd_data;
	logic                  rsp_valid;
	logic [DATA_W-1:0]     rsp_data;
	logic                  rsp_err;
	// wired-and with pull-up
	assign autoboot_request_pin = !((host_boot_oe && !host_boot_out) ||
		(dev_irq_oe && !dev_irq_out));
	modport host (
		output dev_reset_n, page_lines, memory_bank_select, mode_pins,
		output host_boot_out, host_boot_oe, cmd_valid, cmd_code, cmd_data,
		input  autoboot_request_pin, rsp_valid, rsp_data, rsp_err
	);
	modport dev (
		input  dev_reset_n, mode_pins, autoboot_request_pin, cmd_valid, cmd_code, cmd_data,
		output dev_irq_out, dev_irq_oe, rsp_valid, rsp_data, rsp_err
	);
endinterface
`default_nettype wire

//--- pas_device.sv
// decoder end: autoboot loader from external ROM, command answers, configuration window
// assumes host drives reset, boot and mode pins asynchronously; ROM data settles within access time
`timescale 1ns/10ps
`default_nettype none
module pas_device
	import pas_pkg::*;
#(
	parameter int LOAD_BYTES = PAGE_BYTES,
	parameter int ROM_WAIT   = ROM_WAIT_CYC,
	parameter int VAR_ADDR   = VAR_OFFSET
)(
	// clock and power reset
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	// link
	pas_link_if.dev                  link,
	// external ROM
	output logic [LATCH_AW-1:0]      rom_addr_out,
	output logic                     rom_rd_out,
	input  wire logic [DATA_W-1:0]   rom_data_in,
	// application side
	input  wire logic                irq_req_in,
	output logic                     app_ready_out,
	output logic                     cfg_open_out,
	output logic [DATA_W-1:0]        hw_cfg_out,
	output logic [MODE_W-1:0]        mode_out
);
	generate
		if (LOAD_BYTES < 1 || LOAD_BYTES > PAGE_BYTES || ROM_WAIT < 1 || ROM_WAIT > 250 ||
			VAR_ADDR >= LOAD_BYTES)
			$error("pas_device: unsupported parameters");
	endgenerate

	typedef enum logic [3:0] {
		D_HOLD = 4'h1,
		D_IDLE = 4'h2,
		D_LOAD = 4'h4,
		D_RUN  = 4'h8
	} pas_dstate_t;

	pas_dstate_t         state;
	logic [1:0]          rst_sync;
	logic [1:0]          boot_sync;
	logic [MODE_W-1:0]   mode_s1;
	logic [MODE_W-1:0]   mode_s2;
	logic [DATA_W-1:0]   rom_s1;
	logic [DATA_W-1:0]   rom_s2;
	logic                rst_q;
	logic [PAGE_AW-1:0]  addr;
	logic [7:0]          wait_cnt;
	logic                loaded;
	logic                in_open;
	logic [DATA_W-1:0]   var_value;
	logic                irq_oe;
	logic                rsp_valid;
	logic [DATA_W-1:0]   rsp_data;
	logic                rsp_err;

	wire reset_rise = rst_sync[1] && !rst_q;
	wire load_last  = addr == PAGE_AW'(LOAD_BYTES - 1);
	wire running    = state == D_RUN;
	wire [DATA_W-1:0] cfg_in_only = (hw_cfg_out & ~CFG_IN_MASK) | (link.cmd_data & CFG_IN_MASK);
	wire [7:0]        wait_load   = 8'(ROM_WAIT + SYNC_STAGES);

	assign rom_addr_out     = {1'b0, addr};
	assign link.dev_irq_out = 1'b0;
	assign link.dev_irq_oe  = irq_oe;
	assign link.rsp_valid   = rsp_valid;
	assign link.rsp_data    = rsp_data;
	assign link.rsp_err     = rsp_err;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_sync  <= 2'h0;
			boot_sync <= 2'h3;
			mode_s1   <= '0;
			mode_s2   <= '0;
			rom_s1    <= '0;
			rom_s2    <= '0;
			rst_q     <= 1'b0;
		end
		else
		begin
			rst_sync  <= {rst_sync[0], link.dev_reset_n};
			boot_sync <= {boot_sync[0], link.autoboot_request_pin};
			mode_s1   <= link.mode_pins;
			mode_s2   <= mode_s1;
			rom_s1    <= rom_data_in;
			rom_s2    <= rom_s1;
			rst_q     <= rst_sync[1];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state         <= D_HOLD;
			addr          <= '0;
			wait_cnt      <= 8'h00;
			rom_rd_out    <= 1'b0;
			loaded        <= 1'b0;
			app_ready_out <= 1'b0;
			cfg_open_out  <= 1'b0;
			in_open       <= 1'b0;
			hw_cfg_out    <= CFG_DEFAULT;
			mode_out      <= '0;
			var_value     <= '0;
		end
		else if (!rst_sync[1])
		begin
			state         <= D_HOLD;
			rom_rd_out    <= 1'b0;
			app_ready_out <= 1'b0;
			cfg_open_out  <= 1'b0;
			in_open       <= 1'b0;
		end
		else if (reset_rise)
		begin
			mode_out <= mode_s2;
			hw_cfg_out <= CFG_DEFAULT;
			if (!boot_sync[1])
			begin
				state      <= D_LOAD;
				loaded     <= 1'b0;
				addr       <= '0;
				wait_cnt   <= wait_load;
				rom_rd_out <= 1'b1;
			end
			else if (loaded)
			begin
				// soft reset keeps the resident image
				state         <= D_RUN;
				app_ready_out <= 1'b1;
				cfg_open_out  <= 1'b1;
			end
			else
				state <= D_IDLE;
		end
		else
		begin
			unique case (state)
				D_HOLD, D_IDLE:
				begin
				end
				D_LOAD:
				begin
					if (wait_cnt != 8'h00)
						wait_cnt <= wait_cnt - 8'h01;
					else
					begin
						if (addr == PAGE_AW'(VAR_ADDR))
							var_value <= rom_s2;
						if (load_last)
						begin
							state         <= D_RUN;
							rom_rd_out    <= 1'b0;
							loaded        <= 1'b1;
							app_ready_out <= 1'b1;
							cfg_open_out  <= 1'b1;
						end
						else
						begin
							addr     <= addr + PAGE_AW'(1);
							wait_cnt <= wait_load;
						end
					end
				end
				D_RUN:
				begin
					if (link.cmd_valid)
					begin
						unique case (link.cmd_code)
							PAS_CMD_CONFIG:
							begin
								if (cfg_open_out)
									hw_cfg_out <= link.cmd_data;
								else if (in_open)
									hw_cfg_out <= cfg_in_only;
							end
							PAS_CMD_KICK:
							begin
								cfg_open_out <= 1'b0;
								in_open      <= 1'b0;
							end
							PAS_CMD_RESTART:
								in_open <= !cfg_open_out;
							PAS_CMD_READ:
							begin
							end
						endcase
					end
				end
			endcase
		end
	end

	// answers one cycle after each command; refused config shows as rsp_err
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
			rsp_err   <= 1'b0;
			irq_oe    <= 1'b0;
		end
		else
		begin
			rsp_valid <= link.cmd_valid;
			rsp_data  <= (link.cmd_code == PAS_CMD_READ) ? var_value : hw_cfg_out;
			rsp_err   <= !running || (link.cmd_code == PAS_CMD_CONFIG && !cfg_open_out &&
				!in_open);
			irq_oe    <= app_ready_out && irq_req_in && rst_sync[1];
		end
	end
endmodule
`default_nettype wire

//--- pas_props.sv
// link checker: boot pin, device reset, load wait and verify-read timing
// assumes one clock for both ends; the bench wires it to the link signals
`timescale 1ns/10ps
`default_nettype none
module pas_props
	import pas_pkg::*;
#(
	parameter int LOAD_CYC  = 2000,
	parameter int RETRY_CYC = 20,
	parameter int RST_CYC   = 4
)(
	// clock and reset
	input wire logic              clk_in,
	input wire logic              rst_n_in,
	// link
	input wire logic              dev_reset_n,
	input wire logic [MODE_W-1:0] mode_pins,
	input wire logic              host_boot_out,
	input wire logic              host_boot_oe,
	input wire logic              dev_irq_out,
	input wire logic              dev_irq_oe,
	input wire logic              autoboot_request_pin,
	input wire logic              cmd_valid,
	input wire pas_cmd_t          cmd_code,
	input wire logic              rsp_valid
);
	logic [15:0] up_cnt;
	logic [15:0] lo_cnt;
	logic [15:0] rd_gap;
	wire         rd_cmd = cmd_valid && cmd_code == PAS_CMD_READ;
	// device may still pull the pin for its two sync stages after its reset falls
	wire         irq_ok = dev_reset_n ? (up_cnt > 16'h2 && !host_boot_oe) : lo_cnt < 16'h3;
	// cycles out of reset, cycles in reset, cycles since the last read
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			up_cnt <= 16'h0;
			lo_cnt <= 16'h0;
			rd_gap <= 16'hffff;
		end
		else
		begin
			up_cnt <= !dev_reset_n ? 16'h0 : up_cnt + {15'h0, !(&up_cnt)};
			lo_cnt <= dev_reset_n ? 16'h0 : lo_cnt + {15'h0, !(&lo_cnt)};
			rd_gap <= rd_cmd ? 16'h0 : (!dev_reset_n ? 16'hffff : rd_gap + {15'h0, !(&rd_gap)});
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence released;
		$rose(dev_reset_n);
	endsequence
	sequence answered;
		##1 rsp_valid ##1 !rsp_valid;
	endsequence
	a_pin_open_drain: assert property (!host_boot_out && !dev_irq_out)
		else $error("boot pin driven high");
	a_boot_req_held: assert property (released |-> !autoboot_request_pin && $past(host_boot_oe))
		else $error("boot request not low at reset release");
	a_reset_width: assert property (released |-> lo_cnt >= RST_CYC)
		else $error("device reset too short");
	a_retry_rerequest: assert property ($fell(dev_reset_n) |-> host_boot_oe)
		else $error("reset without boot request");
	a_load_quiet: assert property (rd_cmd |-> up_cnt >= LOAD_CYC)
		else $error("read before load wait ended");
	a_retry_spacing: assert property (rd_cmd |-> rd_gap >= RETRY_CYC)
		else $error("second read too early");
	a_cmd_answer: assert property (cmd_valid |-> answered)
		else $error("command not answered in one cycle");
	a_irq_after_load: assert property (dev_irq_oe |-> irq_ok)
		else $error("device drives pin before download");
	a_boot_drive_brief: assert property (host_boot_oe |-> !dev_reset_n || !$past(dev_reset_n))
		else $error("boot pin driven outside reset");
	a_mode_setup: assert property (released |-> $stable(mode_pins)[*3])
		else $error("mode pins moved around reset release");
endmodule
`default_nettype wire

//--- paged_autoboot_sequencer_bench.sv
// bench: host and decoder joined by the link, AXI4-Lite master, paged ROM, reference model
// assumes shortened load, retry and reset counts; ROM holds eight pages of 32 bytes
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); \
		end \
	end
module paged_autoboot_sequencer_bench
	import pas_pkg::*;
;
	localparam int          LOADC = 2000;
	localparam int          RETRC = 20;
	localparam int          RSTC  = 4;
	localparam logic [15:0] CSEQ  = 16'h8765;
	logic        clk_in, rst_n_in, irq_o, irq_req, prev_rn, win_full, win_in;
	logic        aw_valid, aw_rdy, w_valid, w_rdy, b_valid, b_ready;
	logic        ar_valid, ar_rdy, r_valid, r_ready;
	logic [7:0]  aw_addr, ar_addr, rom_data, hw_cfg, e, m_cfg;
	logic [31:0] w_data, r_data, rd;
	logic [1:0]  b_resp, r_resp, rs, mode_o, m;
	logic [15:0] rom_addr;
	logic [2:0]  p;
	logic [7:0]  rom [0:255];
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_read = 0;
	int          n_rst = 0;
	int          n_leak = 0;
	int          n_a15 = 0;
	int          cyc = 0;
	int          since_rel = LOADC;
	int          i, r0, f0;
	pas_link_if link ();
	pas_host #(.LOAD_CYC(LOADC), .RETRY_CYC(RETRC), .RST_CYC(RSTC), .BOOTS(MAX_BOOTS)) pas_host_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_rdy),
		.s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_valid),
		.s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid),
		.s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
		.s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
		.s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready), .link(link), .irq_out(irq_o));
	pas_device #(.LOAD_BYTES(32), .ROM_WAIT(2), .VAR_ADDR(16)) pas_device_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .rom_addr_out(rom_addr),
		.rom_rd_out(), .rom_data_in(rom_data), .irq_req_in(irq_req), .app_ready_out(),
		.cfg_open_out(), .hw_cfg_out(hw_cfg), .mode_out(mode_o));
	pas_props #(.LOAD_CYC(LOADC), .RETRY_CYC(RETRC), .RST_CYC(RSTC)) props_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .dev_reset_n(link.dev_reset_n),
		.mode_pins(link.mode_pins), .host_boot_out(link.host_boot_out),
		.host_boot_oe(link.host_boot_oe), .dev_irq_out(link.dev_irq_out),
		.dev_irq_oe(link.dev_irq_oe), .autoboot_request_pin(link.autoboot_request_pin),
		.cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .rsp_valid(link.rsp_valid));
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		do
		begin
			@(posedge clk_in);
			if (aw_rdy) aw_valid <= 1'b0;
			if (w_rdy) w_valid <= 1'b0;
		end while (!b_valid);
		r = b_resp;
		b_ready <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		do
		begin
			@(posedge clk_in);
			if (ar_rdy) ar_valid <= 1'b0;
		end while (!r_valid);
		d = r_data;
		r = r_resp;
		r_ready <= 1'b0;
		@(posedge clk_in);
	endtask
	// start a boot and poll until ready or failed
	task automatic boot(input logic [2:0] pg, input logic [1:0] md);
		axi_wr(REG_CTRL, {25'h0, md, 1'b0, pg, 1'b1}, rs);
		rd = 32'h0;
		while (!rd[1] && !rd[2])
			axi_rd(REG_STATUS, rd, rs);
	endtask
	task automatic cmd_step(input pas_cmd_t c, input logic [7:0] v);
		logic ok;
		ok = c != PAS_CMD_CONFIG || win_full || win_in;
		axi_wr(REG_CMD, {22'h0, c, v}, rs);
		rd = 32'h10;
		while (rd[4])
			axi_rd(REG_STATUS, rd, rs);
		`CHK(rd[5], !ok);
		if (c == PAS_CMD_CONFIG)
			m_cfg = win_full ? v : (win_in ? {m_cfg[7:4], v[3:0]} : m_cfg);
		if (c == PAS_CMD_KICK)
			{win_full, win_in} = 2'b00;
		if (c == PAS_CMD_RESTART)
			win_in = !win_full;
		`CHK(hw_cfg, m_cfg);
		if (c == PAS_CMD_READ)
		begin
			axi_rd(REG_RESULT, rd, rs);
			`CHK(rd[7:0], e);
		end
	endtask
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// paged ROM, event counts and watchdog
	always @(posedge clk_in)
	begin
		rom_data <= rom[{link.page_lines, rom_addr[4:0]}];
		prev_rn <= link.dev_reset_n;
		if (prev_rn === 1'b1 && link.dev_reset_n === 1'b0) n_rst++;
		if (link.cmd_valid === 1'b1 && link.cmd_code === PAS_CMD_READ) n_read++;
		// interrupt stays masked for the whole load wait after each release
		if (since_rel < LOADC && irq_o !== 1'b0) n_leak++;
		if (link.dev_reset_n !== 1'b1)
			since_rel = 0;
		else if (since_rel < LOADC)
			since_rel++;
		if (rst_n_in && rom_addr[15] !== 1'b0) n_a15++;
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		{rst_n_in, aw_valid, w_valid, b_ready, ar_valid, r_ready, irq_req} = '0;
		{aw_addr, ar_addr, w_data} = '0;
		void'($urandom(60911));
		for (i = 0; i < 256; i++)
			rom[i] = 8'($urandom);
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		`CHK(link.page_lines, CTRL_PAGE_RESET);
		axi_rd(REG_CTRL, rd, rs);
		`CHK(rd, 32'h0c);
		axi_rd(REG_EXPECT, rd, rs);
		`CHK(rd, 32'h5a);
		axi_rd(8'h20, rd, rs);
		`CHK(rs, AXI_SLVERR);
		axi_wr(8'h24, 32'h1, rs);
		`CHK(rs, AXI_SLVERR);
		m = 2'($urandom);
		axi_wr(REG_CTRL, {25'h0, m, 1'b1, 3'h6, 1'b0}, rs);
		`CHK(link.memory_bank_select, 1'b1);
		`CHK(link.mode_pins, m);
		$display("test reset and board lines done");
		e = 8'($urandom_range(254, 1));
		p = {2'($urandom), 1'b0};
		rom[{p, 5'd16}] = e;
		rom[{p ^ 3'h2, 5'd16}] = ~e;
		axi_wr(REG_EXPECT, {24'h0, e}, rs);
		irq_req <= 1'b1;
		r0 = n_read;
		boot(p, m);
		`CHK(rd[2:0], 3'h2);
		`CHK(rd[11:8], 4'h1);
		`CHK(n_read - r0, 1);
		`CHK(link.memory_bank_select, 1'b0);
		`CHK(mode_o, m);
		axi_rd(REG_RESULT, rd, rs);
		`CHK(rd[7:0], e);
		repeat (6) @(posedge clk_in);
		`CHK(link.autoboot_request_pin, 1'b0);
		`CHK(irq_o, 1'b1);
		$display("test paged boot done");
		{win_full, win_in, m_cfg} = {2'b10, CFG_DEFAULT};
		`CHK(hw_cfg, CFG_DEFAULT);
		for (i = 0; i < 8; i++)
			cmd_step(pas_cmd_t'(CSEQ[2*i +: 2]), 8'($urandom));
		$display("test configuration window done");
		r0 = n_read;
		f0 = n_rst;
		boot(p ^ 3'h2, ~m);
		`CHK(rd[2:0], 3'h4);
		`CHK(rd[11:8], 4'(MAX_BOOTS));
		`CHK(n_read - r0, 2 * MAX_BOOTS);
		`CHK(n_rst - f0, MAX_BOOTS);
		`CHK(mode_o, ~m);
		`CHK(irq_o, 1'b0);
		`CHK(n_leak, 0);
		`CHK(n_a15, 0);
		$display("test failed boot retries done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
